// file: psc_pkg.sv
// package: constants, types and register map of the serial control port
package psc_pkg;

// ----------------------------------------------------------------------
// Contract
// RULE1 - both main enables low: off, or standby regulator only if enabled
// RULE2 - watchdog pin caught before power-up; low enables, high disables watchdog
// RULE3 - configuration at 10h takes writes only after key unlock
// RULE4 - configuration holds five control bits D4..D0, all zero by default
// RULE5 - configuration survives system reset, cleared only by deep init
// RULE6 - error-input reset bit set: error input pulls reset output low
// RULE7 - clear source bit: 1 serial refresh, 0 refresh pin
// RULE8 - low-voltage reset bit set: regulator-2 detections cause reset
// RULE9 - advanced watchdog only while serial refresh source selected
// RULE10 - closed-window bit set: refresh in closed window causes reset
// RULE11 - fixed read-only product code at 00h
// RULE12 - pin monitor at 02h: watchdog pin D2, error b D1, error a D0
// RULE13 - error inputs sampled every 100us after reset release
// RULE14 - host sends one 16-bit frame, msb first, per select period
// RULE15 - frame latched and acted on at select rising edge
// RULE16 - frame: read select, six address, eight data bits, parity
// RULE17 - data output released during select and address bits
// RULE18 - parity makes the total count of ones odd
// RULE19 - read parity counts select and address bits as ones
// RULE20 - clock count other than 16 discards the frame
// RULE21 - frames to unimplemented addresses are ignored
// RULE22 - parity mismatch discards the frame, no register changes
// RULE23 - host reads key at 11h and writes it back before secured write
// RULE24 - input sampled on rising clock, output changed on falling clock
// RULE25 - unused configuration and monitor bits read zero
// ----------------------------------------------------------------------

localparam logic [5:0] ADDR_ID     = 6'h00;
localparam logic [5:0] ADDR_PIN_LEVEL_MONITOR = 6'h02;
localparam logic [5:0] ADDR_CFG    = 6'h10;
localparam logic [5:0] ADDR_KEY    = 6'h11;

localparam logic [4:0] CNT_ADDR  = 5'h07;
localparam logic [4:0] CNT_PAR   = 5'h0f;
localparam logic [4:0] CNT_FRAME = 5'h10;
localparam logic [4:0] CNT_MAX   = 5'h1f;

localparam logic [7:0] PRODUCT_ID = 8'h5a; // arbitrary value
localparam logic [7:0] KEY_SEED   = 8'h01;
localparam logic [4:0] CFG_RESET  = 5'h00;

localparam int PM_ERRA = 0;
localparam int PM_ERRB = 1;
localparam int PM_WD   = 2;

localparam int ERR_SAMPLE_US  = 100;
localparam int CLK_KHZ        = 10000;
localparam int ERR_SAMPLE_CYC = ERR_SAMPLE_US * CLK_KHZ / 1000;

localparam int SY_ENA  = 0;
localparam int SY_ENB  = 1;
localparam int SY_SBY  = 2;
localparam int SY_WDEN = 3;
localparam int SY_ERRA = 4;
localparam int SY_ERRB = 5;
localparam int SY_WDI  = 6;
localparam int SY_SW2  = 7;
localparam int SY_LDO2 = 8;
localparam int SY_CS   = 9;
localparam int SY_TGL  = 10;
localparam int SY_N    = 11;
localparam logic [SY_N-1:0] SY_RST = 11'h200;

typedef struct packed {
    logic       rd;
    logic [5:0] addr;
    logic [7:0] data;
    logic       par;
} psc_frame_s;

typedef struct packed {
    logic err_rst;
    logic wd_src;
    logic lv_rst;
    logic adv_wd;
    logic cw_rst;
} psc_cfg_s;

typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01,
    ST_EXEC = 2'b10
} psc_state_e;

endpackage

// file: psc_serial_ctrl.sv
// serial control port, secured configuration and pin monitor
`timescale 1ns/1ns
`default_nettype none
module psc_serial_ctrl (
    // clock and deep-init reset
    input  wire logic sys_clk_i,
    input  wire logic resetn_i,
    // serial link
    input  wire logic serial_clock_in_i,
    input  wire logic serial_select_n_i,
    input  wire logic serial_data_in_i,
    output var  logic serial_data_out_o,
    output var  logic serial_data_out_oe_o,
    // pins
    input  wire logic main_enable_a_i,
    input  wire logic main_enable_b_i,
    input  wire logic standby_regulator_enable_i,
    input  wire logic watchdog_enable_pin_i,
    input  wire logic error_input_a_i,
    input  wire logic error_input_b_i,
    input  wire logic watchdog_refresh_pin_i,
    input  wire logic switcher2_lowvolt_detect_i,
    input  wire logic linear2_lowvolt_detect_i,
    // sequencer and watchdog side
    input  wire logic pu_seq_active_i,
    input  wire logic seq_reset_active_i,
    input  wire logic closed_window_trigger_i,
    output var  logic system_reset_out_n_o,
    output var  logic device_operate_o,
    output var  logic standby_only_o,
    output var  logic watchdog_enable_o,
    output var  logic watchdog_refresh_o,
    output var  logic wd_serial_refresh_sel_o,
    output var  logic advanced_watchdog_o
);
    import psc_pkg::*;

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [SY_N-1:0] pin_raw;
    logic [SY_N-1:0] meta_reg;
    logic [SY_N-1:0] sync_reg;
    logic            tgl_reg;

    assign pin_raw[SY_ENA]  = main_enable_a_i;
    assign pin_raw[SY_ENB]  = main_enable_b_i;
    assign pin_raw[SY_SBY]  = standby_regulator_enable_i;
    assign pin_raw[SY_WDEN] = watchdog_enable_pin_i;
    assign pin_raw[SY_ERRA] = error_input_a_i;
    assign pin_raw[SY_ERRB] = error_input_b_i;
    assign pin_raw[SY_WDI]  = watchdog_refresh_pin_i;
    assign pin_raw[SY_SW2]  = switcher2_lowvolt_detect_i;
    assign pin_raw[SY_LDO2] = linear2_lowvolt_detect_i;
    assign pin_raw[SY_CS]   = serial_select_n_i;
    assign pin_raw[SY_TGL]  = tgl_reg;

    for (genvar g = 0; g < SY_N; g++) begin : g_sync
        always_ff @(posedge sys_clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                meta_reg[g] <= SY_RST[g];
                sync_reg[g] <= SY_RST[g];
            end else begin
                meta_reg[g] <= pin_raw[g];
                sync_reg[g] <= meta_reg[g];
            end
        end
    end

    // ------------------------------------------------------------------
    // link domain: receive on rising, send on falling edge
    // ------------------------------------------------------------------
    logic [15:0] shift_reg;
    logic [4:0]  count_reg;
    logic [4:0]  count_next;
    logic        armed_reg;
    logic        arm_set;
    logic        link_rst_n;
    logic [7:0]  tx_reg;
    logic        sdo_reg;
    logic        oe_reg;
    logic        par_reg;
    logic [31:0] snap_reg;
    logic [7:0]  rd_byte;
    logic        rd_map;

    // shift and count hold after the frame so the system side can read
    // them quietly; a new frame restarts the count on its first edge, the shift register just keeps shifting
    assign arm_set    = serial_select_n_i | ~resetn_i;
    assign link_rst_n = resetn_i & ~serial_select_n_i;
    assign count_next = armed_reg ? 5'h01 :
                        (count_reg == CNT_MAX) ? CNT_MAX : count_reg + 5'h01;

    always_ff @(posedge serial_clock_in_i or posedge arm_set) begin
        if (arm_set) begin
            armed_reg <= 1'b1;
        end else begin
            armed_reg <= 1'b0;
        end
    end

    always_ff @(posedge serial_clock_in_i or negedge resetn_i) begin
        if (!resetn_i) begin
            shift_reg <= 16'h0000;
            count_reg <= 5'h00;
            tgl_reg   <= 1'b0;
        end else begin
            shift_reg <= {shift_reg[14:0], serial_data_in_i}; // [RULE24]
            count_reg <= count_next; // [RULE20]
            tgl_reg   <= tgl_reg ^ armed_reg;
        end
    end

    // snapshot is frozen while select is low, so these words are stable
    assign rd_map  = (shift_reg[5:0] == ADDR_ID) || (shift_reg[5:0] == ADDR_PIN_LEVEL_MONITOR) ||
                     (shift_reg[5:0] == ADDR_CFG) || (shift_reg[5:0] == ADDR_KEY);
    assign rd_byte = (shift_reg[5:0] == ADDR_ID)     ? snap_reg[7:0]   :
                     (shift_reg[5:0] == ADDR_PIN_LEVEL_MONITOR) ? snap_reg[15:8]  :
                     (shift_reg[5:0] == ADDR_CFG)    ? snap_reg[23:16] :
                     snap_reg[31:24];

    always_ff @(negedge serial_clock_in_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            tx_reg  <= 8'h00;
            sdo_reg <= 1'b0;
            oe_reg  <= 1'b0;
            par_reg <= 1'b0;
        end else if (count_reg == CNT_ADDR && shift_reg[6] && rd_map) begin
            tx_reg  <= {rd_byte[6:0], 1'b0};
            sdo_reg <= rd_byte[7]; // [RULE16]
            oe_reg  <= 1'b1; // [RULE17]
            par_reg <= ^rd_byte; // [RULE19]
        end else if (oe_reg && count_reg < CNT_PAR) begin
            sdo_reg <= tx_reg[7]; // [RULE24]
            tx_reg  <= {tx_reg[6:0], 1'b0};
        end else if (oe_reg && count_reg == CNT_PAR) begin
            sdo_reg <= par_reg; // [RULE18]
        end else begin
            oe_reg  <= 1'b0;
        end
    end

    assign serial_data_out_o    = sdo_reg;
    assign serial_data_out_oe_o = oe_reg;

    // ------------------------------------------------------------------
    // frame execution on select rising edge
    // ------------------------------------------------------------------
    psc_state_e state_reg;
    psc_state_e state_next;
    psc_frame_s frm;
    psc_cfg_s   cfg_reg;
    logic       tgl_seen_reg;
    logic       exec;
    logic       cnt_ok;
    logic       par_ok;
    logic       accept;
    logic       wr_cfg;
    logic       wr_key;
    logic       rd_key;
    logic       unlock_reg;
    logic [7:0] key_reg;
    logic       key_ok_reg;
    logic [7:0] lfsr_reg;
    logic       cs_s;

    assign cs_s   = sync_reg[SY_CS];
    assign exec   = (state_reg == ST_EXEC); // [RULE15]
    assign frm    = psc_frame_s'(shift_reg);
    // a frame with no clocks leaves the toggle unchanged
    assign cnt_ok = (count_reg == CNT_FRAME) && (sync_reg[SY_TGL] != tgl_seen_reg); // [RULE20]
    assign par_ok = ^frm; // [RULE22]
    assign accept = exec && cnt_ok && par_ok;
    assign wr_cfg = accept && !frm.rd && frm.addr == ADDR_CFG; // [RULE21]
    assign wr_key = accept && !frm.rd && frm.addr == ADDR_KEY;
    assign rd_key = accept && frm.rd && frm.addr == ADDR_KEY;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (!cs_s) begin
                    state_next = ST_BUSY;
                end
            end
            ST_BUSY: begin
                if (cs_s) begin
                    state_next = ST_EXEC;
                end
            end
            ST_EXEC: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg    <= ST_IDLE;
            tgl_seen_reg <= 1'b0;
            lfsr_reg     <= KEY_SEED;
        end else begin
            state_reg    <= state_next;
            tgl_seen_reg <= exec ? sync_reg[SY_TGL] : tgl_seen_reg;
            lfsr_reg     <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
        end
    end

    // only the deep-init reset clears the configuration
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cfg_reg <= psc_cfg_s'(CFG_RESET); // [RULE5]
        end else if (wr_cfg && unlock_reg) begin
            cfg_reg <= psc_cfg_s'(frm.data[4:0]); // [RULE3] [RULE4]
        end
    end

    // unlock holds for exactly the next accepted frame
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            key_reg    <= 8'h00;
            key_ok_reg <= 1'b0;
            unlock_reg <= 1'b0;
        end else if (rd_key) begin
            key_reg    <= snap_reg[31:24];
            key_ok_reg <= 1'b1;
            unlock_reg <= 1'b0;
        end else if (wr_key) begin
            key_ok_reg <= 1'b0;
            unlock_reg <= key_ok_reg && frm.data == key_reg; // [RULE23]
        end else if (accept) begin
            unlock_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // pin monitor and snapshot
    // ------------------------------------------------------------------
    logic [9:0] tick_cnt_reg;
    logic       tick;
    logic [7:0] pin_level_monitor;
    logic       wd_lvl_reg;
    logic       erra_reg;
    logic       errb_reg;

    assign tick   = (tick_cnt_reg == 10'(ERR_SAMPLE_CYC - 1));
    assign pin_level_monitor = {5'h00, wd_lvl_reg, errb_reg, erra_reg}; // [RULE12] [RULE25]

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tick_cnt_reg <= 10'h000;
            erra_reg     <= 1'b0;
            errb_reg     <= 1'b0;
            wd_lvl_reg   <= 1'b0;
        end else begin
            tick_cnt_reg <= (tick || seq_reset_active_i) ? 10'h000 : tick_cnt_reg + 10'h001;
            if (tick && !seq_reset_active_i) begin
                erra_reg <= sync_reg[SY_ERRA]; // [RULE13]
                errb_reg <= sync_reg[SY_ERRB];
            end
            if (pu_seq_active_i) begin
                wd_lvl_reg <= sync_reg[SY_WDEN]; // [RULE2]
            end
        end
    end

    // refreshed only between frames so the link never sees it move
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            snap_reg <= {KEY_SEED, 8'h00, 8'h00, PRODUCT_ID};
        end else if (state_reg == ST_IDLE && cs_s) begin
            snap_reg <= {lfsr_reg, 3'h0, cfg_reg, pin_level_monitor, PRODUCT_ID}; // [RULE11]
        end
    end

    // ------------------------------------------------------------------
    // control outputs
    // ------------------------------------------------------------------
    logic rst_cause;
    logic wdi_prev_reg;

    assign rst_cause = seq_reset_active_i ||
                       (cfg_reg.err_rst && (erra_reg || errb_reg)) || // [RULE6]
                       (cfg_reg.lv_rst && (sync_reg[SY_SW2] || sync_reg[SY_LDO2])) || // [RULE8]
                       (cfg_reg.cw_rst && closed_window_trigger_i); // [RULE10]

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            system_reset_out_n_o    <= 1'b0;
            device_operate_o        <= 1'b0;
            standby_only_o          <= 1'b0;
            watchdog_enable_o       <= 1'b0;
            watchdog_refresh_o      <= 1'b0;
            wd_serial_refresh_sel_o <= 1'b0;
            advanced_watchdog_o     <= 1'b0;
            wdi_prev_reg            <= 1'b0;
        end else begin
            system_reset_out_n_o    <= !rst_cause;
            device_operate_o        <= sync_reg[SY_ENA] || sync_reg[SY_ENB]; // [RULE1]
            standby_only_o          <= !sync_reg[SY_ENA] && !sync_reg[SY_ENB] && sync_reg[SY_SBY];
            watchdog_enable_o       <= !wd_lvl_reg; // [RULE2]
            wdi_prev_reg            <= sync_reg[SY_WDI]; // [RULE7]
            watchdog_refresh_o      <= !cfg_reg.wd_src && sync_reg[SY_WDI] && !wdi_prev_reg;
            wd_serial_refresh_sel_o <= cfg_reg.wd_src; // [RULE7]
            advanced_watchdog_o     <= cfg_reg.adv_wd && cfg_reg.wd_src; // [RULE9]
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_cnt_discard;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (exec && !cnt_ok) |=> (cfg_reg == $past(cfg_reg));
    endproperty
    a_cnt_discard: assert property (p_cnt_discard) else $error("bad count wrote cfg"); // [RULE20]

    property p_par_discard;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (exec && !(^frm)) |=> $stable(cfg_reg) && $stable(unlock_reg);
    endproperty
    a_par_discard: assert property (p_par_discard) else $error("bad parity acted"); // [RULE22]

    property p_cfg_locked;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (wr_cfg && !unlock_reg) |=> $stable(cfg_reg);
    endproperty
    a_cfg_locked: assert property (p_cfg_locked) else $error("locked config written"); // [RULE3]

    property p_cfg_write;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (wr_cfg && unlock_reg) |=> (5'(cfg_reg) == $past(frm.data[4:0])) ##1 !unlock_reg;
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("config write lost"); // [RULE4]

    property p_err_reset;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (cfg_reg.err_rst && (erra_reg || errb_reg)) |=> !system_reset_out_n_o;
    endproperty
    a_err_reset: assert property (p_err_reset) else $error("error input gave no reset"); // [RULE6]

    property p_enable;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        sync_reg[SY_ENB] |=> device_operate_o && !standby_only_o;
    endproperty
    a_enable: assert property (p_enable) else $error("enable decode wrong"); // [RULE1]

    property p_wd_capture;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        $fell(pu_seq_active_i) |=> (watchdog_enable_o == !$past(sync_reg[SY_WDEN], 2));
    endproperty
    a_wd_capture: assert property (p_wd_capture) else $error("watchdog pin lost"); // [RULE2]

    property p_adv;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        advanced_watchdog_o |-> $past(cfg_reg.wd_src) && $past(cfg_reg.adv_wd);
    endproperty
    a_adv: assert property (p_adv) else $error("advanced mode without serial source"); // [RULE9]

    property p_err_tick;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        !tick |=> $stable(erra_reg) && $stable(errb_reg);
    endproperty
    a_err_tick: assert property (p_err_tick) else $error("error level moved off tick"); // [RULE13]

    property p_sdo_hiz;
        @(negedge serial_clock_in_i) disable iff (!link_rst_n)
        (count_reg < CNT_ADDR) |-> !oe_reg;
    endproperty
    a_sdo_hiz: assert property (p_sdo_hiz) else $error("output driven during address"); // [RULE17]

endmodule
`default_nettype wire

// file: psc_host_model.sv
// host model: serial link master issuing one 16-bit frame per select period
`timescale 1ns/1ns
`default_nettype none
module psc_host_model (
    // link lines driven by the host
    output var  logic serial_clock_o,
    output var  logic serial_select_n_o,
    output var  logic serial_data_o,
    // resolved device data line
    input  wire logic serial_data_line_i
);
    // ------------------------------------------------------------------
    // idle: clock stands low, data rests at its pull-down level
    // ------------------------------------------------------------------
    initial begin
        serial_clock_o    = 1'b0;
        serial_select_n_o = 1'b1;
        serial_data_o     = 1'b0;
    end

    // ------------------------------------------------------------------
    // frame transfer; n other than 16 is used only to provoke a refusal
    // ------------------------------------------------------------------
    task automatic xfer(input logic [15:0] f, input int n, output logic [15:0] rx);
        int i;
        rx = 16'h0000;
        serial_select_n_o = 1'b0; // one select period per request
        #450;
        for (i = 0; i < n; i++) begin
            serial_data_o = f[15 - (i % 16)]; // msb first, set while clock low
            #8 serial_clock_o = 1'b1;
            rx = {rx[14:0], serial_data_line_i}; // reply taken at rising edge
            #7 serial_clock_o = 1'b0;
        end
        #20 serial_select_n_o = 1'b1; // select rises after the frame
        serial_data_o = 1'b0;
        #700;
    endtask
endmodule
`default_nettype wire

// file: psc_serial_ctrl_tb.sv
// self-checking bench of the serial control port
`timescale 1ns/1ns
`default_nettype none
module psc_serial_ctrl_tb;
    import psc_pkg::*;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic        sys_clk_i, resetn_i, sck, sel_n, sdi, sdo, oe, sdo_line;
    logic        ena, enb, sby, wden, erra, errb, watchdog_refresh_pin, sw2, ldo2, pu_seq, seq_rst, cw;
    logic        rst_n, op, sb, wde, wref, wsel, adv;
    logic [15:0] rx;
    logic [7:0]  key;
    int          num_errors = 0;
    int          checked = 0;
    int          nref = 0;
    int          nlow = 0;
    int          n0, i;
    // rows: main a, main b, standby enable -> operate, standby only
    logic [4:0]  en_rows [8] = '{5'b000_00, 5'b001_01, 5'b010_10, 5'b011_10,
                                 5'b100_10, 5'b101_10, 5'b110_10, 5'b111_10};

    // pull-up holds the data line high while the device is off it
    assign sdo_line = oe ? sdo : 1'b1;

    psc_serial_ctrl u_psc_serial_ctrl (
        .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .serial_clock_in_i(sck),
        .serial_select_n_i(sel_n), .serial_data_in_i(sdi), .serial_data_out_o(sdo),
        .serial_data_out_oe_o(oe), .main_enable_a_i(ena), .main_enable_b_i(enb),
        .standby_regulator_enable_i(sby), .watchdog_enable_pin_i(wden),
        .error_input_a_i(erra), .error_input_b_i(errb), .watchdog_refresh_pin_i(watchdog_refresh_pin),
        .switcher2_lowvolt_detect_i(sw2), .linear2_lowvolt_detect_i(ldo2),
        .pu_seq_active_i(pu_seq), .seq_reset_active_i(seq_rst),
        .closed_window_trigger_i(cw), .system_reset_out_n_o(rst_n),
        .device_operate_o(op), .standby_only_o(sb), .watchdog_enable_o(wde),
        .watchdog_refresh_o(wref), .wd_serial_refresh_sel_o(wsel),
        .advanced_watchdog_o(adv));

    psc_host_model u_psc_host_model (
        .serial_clock_o(sck), .serial_select_n_o(sel_n), .serial_data_o(sdi),
        .serial_data_line_i(sdo_line));

    initial begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end

    always @(posedge sys_clk_i) begin
        if (wref === 1'b1) nref++;
        if (rst_n === 1'b0) nlow++;
    end

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        checked++;
        if (got !== exp) begin
            $display("wrong value at %0t ns: %s", $time, msg);
            num_errors++;
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask

    function automatic logic [15:0] mk(input logic r, input logic [5:0] a, input logic [7:0] d);
        return {r, a, d, ~^{r, a, d}}; // odd count of ones over the frame
    endfunction

    task automatic rd(input logic [5:0] a);
        u_psc_host_model.xfer(mk(1'b1, a, 8'h00), 16, rx);
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        u_psc_host_model.xfer(mk(1'b0, a, d), 16, rx);
    endtask

    // key read and written back right before the secured write
    task automatic unlock;
        rd(ADDR_KEY);
        key = rx[8:1];
        wr(ADDR_KEY, key);
    endtask

    task automatic final_report;
        if (num_errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // slack over the expected half millisecond of traffic
    initial begin
        #2000000;
        num_errors++;
        final_report;
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        {resetn_i, ena, enb, sby, wden, erra, errb, watchdog_refresh_pin, sw2, ldo2, pu_seq, seq_rst, cw} = '0;
        repeat (5) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        cyc(5);
        for (i = 0; i < 8; i++) begin
            {ena, enb, sby} <= en_rows[i][4:2];
            cyc(6);
            chk(16'({op, sb}), 16'(en_rows[i][1:0]), "enable decode");
        end
        wden <= 1'b1;
        pu_seq <= 1'b1;
        cyc(5);
        pu_seq <= 1'b0;
        wden <= 1'b0;
        errb <= 1'b1;
        watchdog_refresh_pin <= 1'b1;
        cyc(5);
        watchdog_refresh_pin <= 1'b0;
        chk(16'(wde), 16'h0000, "watchdog enable");
        chk(16'(nref), 16'h0001, "pin refresh");
        rd(ADDR_ID);
        chk(rx, {7'h7f, PRODUCT_ID, ^PRODUCT_ID}, "product code");
        rd(6'h3f);
        chk(rx, 16'hffff, "unmapped read");
        cyc(1100);
        rd(ADDR_PIN_LEVEL_MONITOR);
        chk(16'(rx[8:1]), 16'h0006, "pin monitor");
        chk(16'(rst_n), 16'h0001, "error reset off");
        wr(ADDR_CFG, 8'hff);
        rd(ADDR_CFG);
        chk(16'(rx[8:1]), 16'h0000, "locked write");
        // short count, long count, flipped parity
        for (i = 0; i < 3; i++) begin
            unlock;
            u_psc_host_model.xfer(mk(1'b0, ADDR_CFG, 8'hff) ^ 16'(i == 2),
                                  15 + 2 * (i % 2) + (i / 2), rx);
            rd(ADDR_CFG);
            chk(16'(rx[8:1]), 16'h0000, "refused frame");
        end
        unlock;
        wr(ADDR_CFG, 8'hff);
        cyc(5);
        rd(ADDR_CFG);
        chk(16'(rx[8:1]), 16'h001f, "config write");
        chk(16'({wsel, adv}), 16'h0003, "serial refresh, advanced");
        watchdog_refresh_pin <= 1'b1;
        cyc(5);
        watchdog_refresh_pin <= 1'b0;
        chk(16'(nref), 16'h0001, "pin refresh ignored");
        cyc(1100);
        chk(16'(rst_n), 16'h0000, "error reset on");
        errb <= 1'b0;
        erra <= 1'b1;
        cyc(1100);
        rd(ADDR_PIN_LEVEL_MONITOR);
        chk(16'(rx[8:1]), 16'h0005, "pin monitor error a");
        chk(16'(rst_n), 16'h0000, "error a reset on");
        erra <= 1'b0;
        cyc(1100);
        chk(16'(rst_n), 16'h0001, "error cleared");
        sw2 <= 1'b1;
        cyc(5);
        chk(16'(rst_n), 16'h0000, "low voltage reset");
        sw2 <= 1'b0;
        ldo2 <= 1'b1;
        cyc(5);
        chk(16'(rst_n), 16'h0000, "linear low voltage reset");
        ldo2 <= 1'b0;
        cyc(5);
        n0 = nlow;
        cw <= 1'b1;
        cyc(1);
        cw <= 1'b0;
        cyc(5);
        chk(16'(nlow > n0), 16'h0001, "closed window reset");
        seq_rst <= 1'b1;
        cyc(5);
        chk(16'(rst_n), 16'h0000, "system reset asserted");
        seq_rst <= 1'b0;
        cyc(5);
        rd(ADDR_CFG);
        chk(16'(rx[8:1]), 16'h001f, "config kept over reset");
        resetn_i <= 1'b0;
        cyc(3);
        resetn_i <= 1'b1;
        cyc(5);
        rd(ADDR_CFG);
        chk(16'(rx[8:1]), 16'(CFG_RESET), "config default");
        final_report;
    end
endmodule
`default_nettype wire
